// [design/eiac_cfg.svh]
// Constants for the nonvolatile configuration access controller
`ifndef EIAC_CFG_SVH
`define EIAC_CFG_SVH
`define EIAC_OFS_KEY 8'h31
`define EIAC_OFS_STATUS 8'h32
`define EIAC_OFS_ADDR 8'h33
`define EIAC_OFS_WDATA 8'h34
`define EIAC_OFS_CTRL 8'h35
`define EIAC_OFS_RDATA 8'h36
`define EIAC_CFG_FIRST 8'h90
`define EIAC_CFG_LAST 8'h96
`define EIAC_CFG_WORDS 7
`define EIAC_UNLOCK_KEY 16'hC0DE
`define EIAC_BIT_SHADOW 12
`define EIAC_BIT_REFRESH 8
`define EIAC_BIT_WNR 2
`define EIAC_MODE_HI 1
`define EIAC_READY_BIT 0
`define EIAC_ZERO16 16'h0000
`define EIAC_WRITE_CYCLES 16
`endif

// [design/eiac_pkg.sv]
// Types shared by the nonvolatile configuration access controller
package eiac_pkg;
	typedef enum logic [1:0] {
		EIAC_MODE_OFF = 2'h0,
		EIAC_MODE_SINGLE = 2'h1,
		EIAC_MODE_MASS = 2'h2,
		EIAC_MODE_RSVD = 2'h3
	} eiac_mode_t;

	typedef struct packed {
		logic shadow_enable;
		logic shadow_refresh;
		logic write_not_read;
		eiac_mode_t nvm_access_mode;
	} eiac_ctrl_t;

	typedef enum logic [1:0] {
		EIAC_ST_IDLE = 2'b01,
		EIAC_ST_BUSY = 2'b10
	} eiac_state_t;
endpackage

// [design/eiac_ctrl.sv]
// Register-level access controller for the configuration nonvolatile memory
// How it works
// RULE1 - Low byte of the address register picks the word; 0x90 is the first word.
// RULE2 - Write-data register is programmed into the addressed word on a single write.
// RULE3 - Shadow enable makes operation and register reads use shadow values.
// RULE4 - Refresh bit copies memory contents into the shadow words, then clears.
// RULE5 - Direction bit: 0 reads, 1 writes.
// RULE6 - Mode 00 off, 01 single word, 10 mass, 11 reserved and ignored.
// RULE7 - Reserved bits read as zero; the host leaves them alone.
// RULE8 - Control fields clear to zero at reset.
// RULE9 - Read-data register holds the word fetched by the last single read.
// RULE10 - Status bit 0 is 1 when ready; host waits for it.
// RULE11 - Configuration words are reachable only while the unlock key is held; a refresh still copies memory into the shadow words while locked.
// RULE12 - Host unlocks, checks ready, loads address and data, then starts the access.
`include "eiac_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eiac_ctrl #(
	parameter int WRITE_CYCLES = `EIAC_WRITE_CYCLES,
	parameter int WORDS = `EIAC_CFG_WORDS
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	output logic [WORDS*16-1:0] op_cfg_out
);
	localparam int CW = $clog2(WRITE_CYCLES + 1);

	// True when the address falls inside the configuration word range
	function automatic logic in_cfg(input logic [7:0] a);
		in_cfg = (a >= `EIAC_CFG_FIRST) && (a <= `EIAC_CFG_LAST);
	endfunction

	// Index of a configuration word
	function automatic logic [2:0] cfg_idx(input logic [7:0] a);
		logic [7:0] d;
		d = a - `EIAC_CFG_FIRST;
		cfg_idx = d[2:0];
	endfunction

	logic [15:0] key_ff;
	logic [7:0] addr_ff;
	logic [15:0] wdata_ff;
	logic [15:0] rdata_ff;
	eiac_pkg::eiac_ctrl_t ctrl_ff;
	eiac_pkg::eiac_state_t state_ff;
	logic [CW-1:0] busy_cnt_ff;
	logic [15:0] nvm_q [WORDS];
	logic [15:0] shadow_q [WORDS];
	logic key_ok;
	logic ready;
	logic ctrl_wr;
	logic launch;
	logic mass_go;
	logic cfg_wr;
	logic [15:0] ctrl_rd;
	logic [15:0] nxt_rdata;
	eiac_pkg::eiac_ctrl_t wr_ctrl;

	assign key_ok = (key_ff == `EIAC_UNLOCK_KEY); // RULE11
	assign ready = (state_ff == eiac_pkg::EIAC_ST_IDLE); // RULE10
	assign ctrl_wr = ce_in && reg_wr_in && (reg_addr_in == `EIAC_OFS_CTRL);
	assign cfg_wr = ce_in && reg_wr_in && in_cfg(reg_addr_in) && key_ok; // RULE11
	assign wr_ctrl.shadow_enable = reg_wdata_in[`EIAC_BIT_SHADOW];
	assign wr_ctrl.shadow_refresh = reg_wdata_in[`EIAC_BIT_REFRESH];
	assign wr_ctrl.write_not_read = reg_wdata_in[`EIAC_BIT_WNR];
	assign wr_ctrl.nvm_access_mode = eiac_pkg::eiac_mode_t'(reg_wdata_in[`EIAC_MODE_HI:0]);
	// A single-word start is only honoured when unlocked, idle and aimed at a real word
	assign launch = ctrl_wr && ready && key_ok && in_cfg(addr_ff)
		&& (wr_ctrl.nvm_access_mode == eiac_pkg::EIAC_MODE_SINGLE); // RULE6
	assign mass_go = ctrl_wr && ready && key_ok
		&& (wr_ctrl.nvm_access_mode == eiac_pkg::EIAC_MODE_MASS); // RULE6

	// Key, address and write-data registers
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			key_ff <= `EIAC_ZERO16;
			addr_ff <= '0;
			wdata_ff <= `EIAC_ZERO16;
		end else if (ce_in && reg_wr_in) begin
			if (reg_addr_in == `EIAC_OFS_KEY)
				key_ff <= reg_wdata_in;
			if (reg_addr_in == `EIAC_OFS_ADDR)
				addr_ff <= reg_wdata_in[7:0]; // RULE1
			if (reg_addr_in == `EIAC_OFS_WDATA)
				wdata_ff <= reg_wdata_in; // RULE2
		end
	end

	// Control register; refresh is a request that clears itself once served
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_ff <= '0; // RULE8
		end else if (ce_in) begin
			if (ctrl_wr)
				ctrl_ff <= wr_ctrl;
			else if (ctrl_ff.shadow_refresh)
				ctrl_ff.shadow_refresh <= 1'b0; // RULE4
		end
	end

	// Busy sequencing: programming holds the memory not-ready for a fixed time
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= eiac_pkg::EIAC_ST_IDLE;
			busy_cnt_ff <= '0;
		end else if (ce_in) begin
			unique case (state_ff)
				eiac_pkg::EIAC_ST_IDLE: begin
					if ((launch || mass_go) && wr_ctrl.write_not_read) begin // RULE5
						state_ff <= eiac_pkg::EIAC_ST_BUSY;
						busy_cnt_ff <= CW'(WRITE_CYCLES - 1);
					end
				end
				eiac_pkg::EIAC_ST_BUSY: begin
					if (busy_cnt_ff == '0)
						state_ff <= eiac_pkg::EIAC_ST_IDLE;
					else
						busy_cnt_ff <= busy_cnt_ff - 1'b1;
				end
				default: begin
					state_ff <= eiac_pkg::EIAC_ST_IDLE;
				end
			endcase
		end
	end

	// Nonvolatile words: single write programs one, mass write programs all from shadow
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < WORDS; i++)
				nvm_q[i] <= `EIAC_ZERO16;
		end else if (ce_in) begin
			if (launch && wr_ctrl.write_not_read)
				nvm_q[cfg_idx(addr_ff)] <= wdata_ff; // RULE2
			else if (mass_go && wr_ctrl.write_not_read)
				for (int i = 0; i < WORDS; i++)
					nvm_q[i] <= shadow_q[i];
		end
	end

	// Shadow words: refresh or mass read reloads them, register writes edit them
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int i = 0; i < WORDS; i++)
				shadow_q[i] <= `EIAC_ZERO16;
		end else if (ce_in) begin
			if (ctrl_ff.shadow_refresh || (mass_go && !wr_ctrl.write_not_read)) begin
				for (int i = 0; i < WORDS; i++)
					shadow_q[i] <= nvm_q[i]; // RULE4
			end else if (cfg_wr) begin
				shadow_q[cfg_idx(reg_addr_in)] <= reg_wdata_in;
			end
		end
	end

	// Single read latches the selected word for the read-data register
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			rdata_ff <= `EIAC_ZERO16;
		else if (ce_in && launch && !wr_ctrl.write_not_read)
			rdata_ff <= ctrl_ff.shadow_enable ? shadow_q[cfg_idx(addr_ff)]
				: nvm_q[cfg_idx(addr_ff)]; // RULE9
	end

	// Words that the rest of the device runs from
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			op_cfg_out <= '0;
		end else if (ce_in) begin
			for (int i = 0; i < WORDS; i++)
				op_cfg_out[i*16 +: 16] <= ctrl_ff.shadow_enable ? shadow_q[i] : nvm_q[i]; // RULE3
		end
	end

	// Read mux; reserved fields are tied to zero
	always_comb begin
		ctrl_rd = `EIAC_ZERO16;
		ctrl_rd[`EIAC_BIT_SHADOW] = ctrl_ff.shadow_enable;
		ctrl_rd[`EIAC_BIT_REFRESH] = ctrl_ff.shadow_refresh;
		ctrl_rd[`EIAC_BIT_WNR] = ctrl_ff.write_not_read;
		ctrl_rd[`EIAC_MODE_HI:0] = ctrl_ff.nvm_access_mode; // RULE7
		nxt_rdata = `EIAC_ZERO16;
		if (in_cfg(reg_addr_in)) begin
			if (key_ok)
				nxt_rdata = ctrl_ff.shadow_enable ? shadow_q[cfg_idx(reg_addr_in)]
					: nvm_q[cfg_idx(reg_addr_in)]; // RULE3
		end else begin
			unique case (reg_addr_in)
				`EIAC_OFS_KEY: nxt_rdata = key_ff;
				`EIAC_OFS_STATUS: nxt_rdata[`EIAC_READY_BIT] = ready; // RULE10
				`EIAC_OFS_ADDR: nxt_rdata[7:0] = addr_ff; // RULE7
				`EIAC_OFS_WDATA: nxt_rdata = wdata_ff;
				`EIAC_OFS_CTRL: nxt_rdata = ctrl_rd;
				`EIAC_OFS_RDATA: nxt_rdata = rdata_ff;
				default: nxt_rdata = `EIAC_ZERO16;
			endcase
		end
	end

	// Read data is registered; it holds until the next read strobe
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			reg_rdata_out <= `EIAC_ZERO16;
		else if (ce_in && reg_rd_in)
			reg_rdata_out <= nxt_rdata;
	end

	logic [WORDS*16-1:0] nvm_flat;
	logic [WORDS*16-1:0] shadow_flat;
	always_comb begin
		for (int i = 0; i < WORDS; i++) begin
			nvm_flat[i*16 +: 16] = nvm_q[i];
			shadow_flat[i*16 +: 16] = shadow_q[i];
		end
	end

	sequence s_single_write;
		launch && wr_ctrl.write_not_read;
	endsequence
	sequence s_single_read;
		launch && !wr_ctrl.write_not_read;
	endsequence

	property p_addr_upper_zero;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		ce_in && reg_rd_in && reg_addr_in == `EIAC_OFS_ADDR |=> reg_rdata_out[15:8] == 8'h00;
	endproperty
	a_addr_upper_zero: assert property (p_addr_upper_zero) else $error("upper byte set"); // RULE1

	property p_write_programs;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		s_single_write |=> nvm_q[cfg_idx(addr_ff)] == $past(wdata_ff);
	endproperty
	a_write_programs: assert property (p_write_programs) else $error("single write lost"); // RULE2

	property p_shadow_read;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		ce_in && reg_rd_in && in_cfg(reg_addr_in) && key_ok && ctrl_ff.shadow_enable
			|=> reg_rdata_out == $past(shadow_q[cfg_idx(reg_addr_in)]);
	endproperty
	a_shadow_read: assert property (p_shadow_read) else $error("shadow not returned"); // RULE3

	property p_refresh;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		ce_in && ctrl_ff.shadow_refresh && !ctrl_wr
			|=> shadow_flat == $past(nvm_flat) && !ctrl_ff.shadow_refresh;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh did not copy"); // RULE4

	property p_write_busy;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(ce_in and s_single_write) |=> !ready [*2];
	endproperty
	a_write_busy: assert property (p_write_busy) else $error("write not busy"); // RULE5

	property p_off_no_op;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		ctrl_wr && wr_ctrl.nvm_access_mode != eiac_pkg::EIAC_MODE_SINGLE
			&& wr_ctrl.nvm_access_mode != eiac_pkg::EIAC_MODE_MASS && ready
			|=> ready && $stable(nvm_flat);
	endproperty
	a_off_no_op: assert property (p_off_no_op) else $error("access in off mode"); // RULE6

	property p_ctrl_reserved;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		ce_in && reg_rd_in && reg_addr_in == `EIAC_OFS_CTRL
			|=> reg_rdata_out[15:13] == 3'h0 && reg_rdata_out[7:3] == 5'h00;
	endproperty
	a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved bits set"); // RULE7

	property p_read_fetch;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		(s_single_read and !ctrl_ff.shadow_enable)
			|=> rdata_ff == $past(nvm_q[cfg_idx(addr_ff)]);
	endproperty
	a_read_fetch: assert property (p_read_fetch) else $error("read data wrong"); // RULE9

	property p_locked;
		@(posedge sys_clk_in) disable iff (!resetn_in)
		!key_ok && !ctrl_ff.shadow_refresh |=> $stable(shadow_flat) && $stable(nvm_flat);
	endproperty
	a_locked: assert property (p_locked) else $error("locked words changed"); // RULE11
endmodule
`default_nettype wire

// [tb/eiac_host.sv]
// Host model issuing register strobes to the access controller
`include "eiac_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eiac_host (
	input wire logic sys_clk_in,
	input wire logic [15:0] rdata_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [15:0] wdata_out
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 16'h0000;
	end
	// One strobe cycle; lines are inverted after so stale values never help
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge sys_clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
	// Read data is registered at the strobe edge, so take it half a cycle later
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge sys_clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(negedge sys_clk_in);
		d = rdata_in;
	endtask
	// Bounded poll so a stuck busy flag cannot hang the host
	task automatic wait_ready(output logic ok);
		logic [15:0] s;
		ok = 1'b0;
		for (int i = 0; i < 40 && !ok; i++) begin
			rd(`EIAC_OFS_STATUS, s);
			ok = (s[0] === 1'b1);
		end
	endtask
	// Ready first, then address, data and the starting control word
	task automatic single(input logic [7:0] a, input logic [15:0] d, input logic [15:0] c,
		output logic ok);
		wait_ready(ok);
		wr(`EIAC_OFS_ADDR, {8'h00, a});
		wr(`EIAC_OFS_WDATA, d);
		wr(`EIAC_OFS_CTRL, c);
	endtask
endmodule
`default_nettype wire

// [tb/eiac_ctrl_bench.sv]
// Self-checking bench for the configuration access controller
`include "eiac_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module eiac_ctrl_bench;
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic ce_in = 1'b0;
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [15:0] v;
	logic [111:0] cfg;
	logic [15:0] mem [7];
	logic [15:0] shd [7];
	logic ok;
	int seed = 32'h15830186;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #5 sys_clk_in = ~sys_clk_in;
	// Short busy time keeps the run brief
	eiac_ctrl #(.WRITE_CYCLES(2)) uut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.ce_in(ce_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_wdata_in(wdata), .reg_rdata_out(rdata), .op_cfg_out(cfg));
	eiac_host host (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .addr_out(addr),
		.wr_out(wr), .rd_out(rd), .wdata_out(wdata));
	// Expected image of the seven words on the operating outputs
	function automatic logic [111:0] pack(input logic [15:0] w [7]);
		for (int k = 0; k < 7; k++) pack[16*k +: 16] = w[k];
	endfunction
	task automatic check(input logic [111:0] seen, input logic [111:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		if (errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Ceiling far above the few hundred cycles the sequence needs
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		for (int k = 0; k < 7; k++) begin
			mem[k] = 16'h0000;
			shd[k] = 16'h0000;
		end
		repeat (8) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		ce_in <= 1'b1;
		// Reset image: only the ready flag is set
		for (int a = 8'h31; a <= 8'h36; a++) begin
			host.rd(8'(a), v);
			check(v, (a == 8'h32) ? 16'h0001 : 16'h0000);
		end
		check(cfg, pack(mem));
		// Locked words ignore a full write sequence
		host.single(8'h90, 16'hA5A5, 16'h0005, ok);
		repeat (4) @(posedge sys_clk_in);
		check(cfg, pack(mem));
		host.rd(8'h90, v);
		check(v, 16'h0000);
		host.wr(`EIAC_OFS_KEY, `EIAC_UNLOCK_KEY);
		// Random single writes to every word, first to last
		for (int k = 0; k < 7; k++) begin
			mem[k] = 16'($random(seed));
			host.single(8'(8'h90 + k), mem[k], 16'h0005, ok);
			check(ok, 1'b1);
		end
		host.wait_ready(ok);
		check(cfg, pack(mem));
		// Single reads, last word first
		for (int k = 6; k >= 0; k--) begin
			host.single(8'(8'h90 + k), ~mem[k], 16'h0001, ok);
			host.rd(`EIAC_OFS_RDATA, v);
			check(v, mem[k]);
		end
		// Disabled and reserved modes leave memory alone
		for (int i = 0; i < 2; i++) begin
			host.single(8'h90, ~mem[0], i ? 16'h0007 : 16'h0004, ok);
		end
		repeat (6) @(posedge sys_clk_in);
		check(cfg, pack(mem));
		// Shadow words are still clear, so operation must see zeros
		host.wr(`EIAC_OFS_CTRL, 16'h1000);
		repeat (3) @(posedge sys_clk_in);
		check(cfg, pack(shd));
		host.rd(8'h90, v);
		check(v, 16'h0000);
		host.wr(`EIAC_OFS_CTRL, 16'h1100);
		shd = mem;
		repeat (4) @(posedge sys_clk_in);
		check(cfg, pack(shd));
		host.rd(`EIAC_OFS_CTRL, v);
		check(v, 16'h1000);
		shd[1] = 16'($random(seed));
		host.wr(8'h91, shd[1]);
		repeat (3) @(posedge sys_clk_in);
		check(cfg, pack(shd));
		// Mass write copies shadow into memory, visible once shadow is off
		host.single(8'h90, 16'h0000, 16'h1006, ok);
		mem = shd;
		host.wait_ready(ok);
		host.wr(`EIAC_OFS_CTRL, 16'h0000);
		repeat (3) @(posedge sys_clk_in);
		check(cfg, pack(mem));
		// A write while the clock enable is low must be dropped
		@(posedge sys_clk_in);
		ce_in <= 1'b0;
		host.wr(`EIAC_OFS_CTRL, 16'h1000);
		ce_in <= 1'b1;
		host.rd(`EIAC_OFS_CTRL, v);
		check(v, 16'h0000);
		// Mass read reloads shadow from memory, undoing a stray shadow edit
		host.wr(8'h92, ~mem[2]);
		host.single(8'h90, 16'h0000, 16'h0002, ok);
		host.wr(`EIAC_OFS_CTRL, 16'h1000);
		repeat (3) @(posedge sys_clk_in);
		check(cfg, pack(mem));
		finish_test();
	end
endmodule
`default_nettype wire
